// [logic/dwb_pkg.sv]
package dwb_pkg;
  localparam int DW = 16;
  localparam int AW = 18;
  localparam int MEM_AW = 7;

  typedef enum logic [2:0] {DWB_NOP, DWB_MRS, DWB_WR, DWB_RD, DWB_PRE} dwb_cmd_t;

  // mode_register_zero layout, carried on the link address lines by a mode-set command
  localparam int BL_LSB = 0;
  localparam int PRE2_BIT = 2;
  localparam int CLAT_LSB = 3;
  localparam int ADDL_LSB = 8;
  localparam int WR_LSB = 13;
  localparam int FW = 5;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_PCMD = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [FW-1:0] CLAT_MIN = 5'h09;
  localparam logic [FW-1:0] CLAT_RST = 5'h09;
  localparam logic [FW-1:0] ADDL_RST = 5'h00;
  localparam logic [FW-1:0] WR_RST = 5'h0c;
  localparam logic [AW-1:0] MODE_RST = {WR_RST, ADDL_RST, CLAT_RST, 1'b0, BL_FIX8};

  // link address bits of a column command
  localparam int AP_BIT = 10;
  localparam int CHOP_BIT = 12;

  localparam logic [3:0] BEATS8 = 4'h8;
  localparam logic [3:0] BEATS4 = 4'h4;
  localparam logic [7:0] CCD_1T = 8'h05;
  localparam logic [7:0] CCD_2T = 8'h06;
  localparam int WTR_S_DEF = 2;
  localparam int WTR_L_DEF = 6;
  localparam int LDIV_DEF = 8;
  localparam int FIFO_DEPTH = 2;

  // controller registers on the AHB-Lite slave
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_WDATA = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam int OP_LSB = 0;
  localparam int BG_LSB = 3;
  localparam int BA_LSB = 5;
  localparam int COL_LSB = 7;
  localparam int CSEL_BIT = 10;
  localparam int APC_BIT = 11;
  localparam int CMDW = 12;

  function automatic logic is_chop(input logic [1:0] bl, input logic sel);
    return (bl == BL_FIX4) || ((bl == BL_PCMD) && !sel);
  endfunction
endpackage

// [logic/dwb_link_if.sv]
`timescale 1ns/100ps
interface dwb_link_if;
  import dwb_pkg::*;
  logic lclk;
  dwb_cmd_t cmd;
  logic [1:0] bg;
  logic [1:0] ba;
  logic [AW-1:0] addr;
  logic [DW-1:0] dq;
  logic dq_en;
  modport ctrl (output lclk, output cmd, output bg, output ba, output addr, output dq,
    output dq_en);
  modport mem (input lclk, input cmd, input bg, input ba, input addr, input dq, input dq_en);
endinterface

// [logic/dwb_mem_end.sv]
`timescale 1ns/100ps
module dwb_mem_end (
  input logic mclk,
  input logic sys_rst,
  input logic ce,
  dwb_link_if.mem lnk,
  input logic [dwb_pkg::MEM_AW-1:0] mem_raddr,
  output logic [dwb_pkg::DW-1:0] mem_rdata,
  output logic burst_chopped,
  output logic recovery_busy,
  output logic precharge_pulse,
  output logic burst_done_pulse
);
  import dwb_pkg::*;
  localparam int SW = 1 + 3 + 2 + 2 + AW + DW;
  typedef enum logic [1:0] {M_IDLE, M_LAT, M_DATA} dwb_mst_t;

  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic lclk_d_reg;
  logic [AW-1:0] mode_reg;
  dwb_mst_t st_reg;
  logic [5:0] lat_reg;
  logic [3:0] beat_reg;
  logic [3:0] beats_reg;
  logic chop_reg;
  logic [1:0] wbg_reg;
  logic [1:0] wba_reg;
  logic [2:0] wcol_reg;
  logic wap_reg;
  logic ap_pend_reg;
  logic [5:0] rec_reg;
  logic busy_reg;
  logic done_reg;
  logic pre_reg;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] mem_arr [0:(1 << MEM_AW)-1];

  // link is slow against mclk: every line but dq_en passes two flops, then sampled on lclk rise
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      lclk_d_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= {lnk.lclk, lnk.cmd, lnk.bg, lnk.ba, lnk.addr, lnk.dq};
      sync2_reg <= sync1_reg;
      lclk_d_reg <= sync2_reg[SW-1];
    end
  end

  wire rise = sync2_reg[SW-1] & ~lclk_d_reg;
  wire dwb_cmd_t s_cmd = dwb_cmd_t'(sync2_reg[SW-2 -: 3]);
  wire [1:0] s_bg = sync2_reg[SW-5 -: 2];
  wire [1:0] s_ba = sync2_reg[SW-7 -: 2];
  wire [AW-1:0] s_addr = sync2_reg[DW +: AW];
  wire [DW-1:0] s_dq = sync2_reg[DW-1:0];
  wire [5:0] wl = {1'b0, mode_reg[ADDL_LSB +: FW]} + {1'b0, mode_reg[CLAT_LSB +: FW]};
  wire new_chop = is_chop(mode_reg[BL_LSB +: 2], s_addr[CHOP_BIT]);
  wire capture = rise && ((st_reg == M_LAT && lat_reg == 6'h01) || st_reg == M_DATA);
  wire last_beat = capture && (beat_reg == beats_reg - 4'h1);

  function automatic logic [2:0] col_at(input logic [2:0] col, input logic [3:0] beat,
                                         input logic chop);
    return chop ? {col[2], col[1:0] + beat[1:0]} : col + beat[2:0];
  endfunction

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= MODE_RST;
    end else if (ce && rise && s_cmd == DWB_MRS) begin
      mode_reg <= s_addr;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= M_IDLE;
      lat_reg <= '0;
      beat_reg <= '0;
      beats_reg <= BEATS8;
      chop_reg <= 1'b0;
      wbg_reg <= '0;
      wba_reg <= '0;
      wcol_reg <= '0;
      wap_reg <= 1'b0;
    end else if (ce && rise) begin
      unique case (st_reg)
        M_IDLE: begin
          if (s_cmd == DWB_WR) begin
            // length decided per command from the field and the select bit
            chop_reg <= new_chop;
            beats_reg <= new_chop ? BEATS4 : BEATS8;
            lat_reg <= wl;
            beat_reg <= '0;
            wbg_reg <= s_bg;
            wba_reg <= s_ba;
            wcol_reg <= s_addr[2:0];
            wap_reg <= s_addr[AP_BIT];
            st_reg <= M_LAT;
          end
        end
        M_LAT: begin
          if (lat_reg == 6'h01) begin
            beat_reg <= 4'h1;
            st_reg <= (beats_reg == 4'h1) ? M_IDLE : M_DATA;
          end else begin
            lat_reg <= lat_reg - 6'h01;
          end
        end
        M_DATA: begin
          beat_reg <= beat_reg + 4'h1;
          if (last_beat) st_reg <= M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && capture) begin
      mem_arr[{wbg_reg, wba_reg, col_at(wcol_reg, beat_reg, chop_reg)}] <= s_dq;
    end
  end

  // recovery counts from the rise after the last beat; an auto-precharge starts when it runs out
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rec_reg <= '0;
      ap_pend_reg <= 1'b0;
      done_reg <= 1'b0;
      pre_reg <= 1'b0;
      rdata_reg <= '0;
      busy_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= last_beat;
      pre_reg <= rise && s_cmd == DWB_PRE;
      rdata_reg <= mem_arr[mem_raddr];
      if (last_beat) begin
        rec_reg <= {1'b0, mode_reg[WR_LSB +: FW]} + 6'h01;
        busy_reg <= 1'b1;
        ap_pend_reg <= wap_reg;
      end else if (rise && rec_reg != 6'h00) begin
        rec_reg <= rec_reg - 6'h01;
        if (rec_reg == 6'h01) busy_reg <= 1'b0;
        if (rec_reg == 6'h01 && ap_pend_reg) begin
          pre_reg <= 1'b1;
          ap_pend_reg <= 1'b0;
        end
      end
    end
  end

  assign mem_rdata = rdata_reg;
  assign burst_chopped = chop_reg;
  assign recovery_busy = busy_reg;
  assign precharge_pulse = pre_reg;
  assign burst_done_pulse = done_reg;
endmodule

// [logic/dwb_ctrl_end.sv]
`timescale 1ns/100ps
module dwb_ctrl_end #(
  parameter int LDIV = dwb_pkg::LDIV_DEF,
  parameter int WTR_S = dwb_pkg::WTR_S_DEF,
  parameter int WTR_L = dwb_pkg::WTR_L_DEF,
  parameter int FD = dwb_pkg::FIFO_DEPTH
) (
  input logic mclk,
  input logic sys_rst,
  input logic ce,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  dwb_link_if.ctrl lnk
);
  import dwb_pkg::*;
  localparam int HALF = LDIV / 2;
  localparam int PW = (FD > 1) ? $clog2(FD) : 1;
  typedef enum logic [2:0] {C_IDLE, C_FILL, C_WAIT, C_LAT, C_DATA} dwb_cst_t;

  logic dph_reg;
  logic dph_wr_reg;
  logic [7:0] dph_addr_reg;
  logic wd_wait_reg;
  logic hready_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_val;
  logic [AW-1:0] mode_reg;
  logic [CMDW-1:0] cmd_reg;
  logic mrs_pend_reg;
  logic cmd_pend_reg;
  logic err_lat_reg;
  logic err_busy_reg;
  logic [DW-1:0] fifo_mem [0:FD-1];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] fcnt_reg;
  logic [7:0] div_reg;
  logic lclk_reg;
  dwb_cst_t st_reg;
  dwb_cmd_t cmd_o_reg;
  logic [1:0] bg_o_reg;
  logic [1:0] ba_o_reg;
  logic [AW-1:0] addr_o_reg;
  logic [DW-1:0] dq_o_reg;
  logic dqen_o_reg;
  logic [DW-1:0] burst_arr [0:7];
  logic [3:0] fill_reg;
  logic [3:0] beats_reg;
  logic [3:0] beat_reg;
  logic [5:0] lat_reg;
  logic [5:0] lead_reg;
  logic [7:0] gap_reg;
  logic [7:0] end_reg;
  logic [1:0] last_bg_reg;
  logic [1:0] last_ba_reg;
  logic wr_seen_reg;
  logic go_ok;
  logic [AW-1:0] cmd_addr;

  wire aph = hsel && htrans[1] && hready;
  wire reg_wr = dph_reg && dph_wr_reg && hready;
  wire fifo_full = fcnt_reg == (PW + 1)'(FD);
  wire push = wd_wait_reg && !fifo_full;
  wire pop = st_reg == C_FILL && fcnt_reg != '0;
  wire ltick = div_reg == 8'(HALF - 1);
  wire dwb_cmd_t op = dwb_cmd_t'(cmd_reg[OP_LSB +: 3]);
  wire [1:0] c_bg = cmd_reg[BG_LSB +: 2];
  wire [1:0] c_ba = cmd_reg[BA_LSB +: 2];
  wire pre2 = mode_reg[PRE2_BIT];
  wire mrs_take = ltick && st_reg == C_IDLE && mrs_pend_reg;
  wire issue = ltick && st_reg == C_WAIT && go_ok;
  wire burst_end = ltick && st_reg == C_DATA && beat_reg == beats_reg;

  function automatic logic [7:0] ccd_min(input logic two_clk);
    return two_clk ? CCD_2T : CCD_1T;
  endfunction

  // AHB-Lite slave: WDATA always takes one wait state, longer while the buffer is full
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dph_reg <= 1'b0;
      dph_wr_reg <= 1'b0;
      dph_addr_reg <= '0;
      wd_wait_reg <= 1'b0;
      hready_reg <= 1'b1;
      hrdata_reg <= '0;
    end else if (ce) begin
      if (hready) begin
        dph_reg <= aph;
        dph_wr_reg <= aph && hwrite;
        dph_addr_reg <= haddr[7:0];
      end
      if (aph && hwrite && haddr[7:0] == A_WDATA) begin
        wd_wait_reg <= 1'b1;
        hready_reg <= 1'b0;
      end else if (push) begin
        wd_wait_reg <= 1'b0;
        hready_reg <= 1'b1;
      end
      if (aph && !hwrite) hrdata_reg <= rd_val;
    end
  end

  always_comb begin
    rd_val = '0;
    case (haddr[7:0])
      A_MODE: rd_val[AW-1:0] = mode_reg;
      A_CMD: rd_val[CMDW-1:0] = cmd_reg;
      A_STAT: rd_val = {24'h0, 1'(fcnt_reg == '0), 1'(fifo_full), err_busy_reg, err_lat_reg,
                        cmd_pend_reg, mrs_pend_reg, 1'(st_reg != C_IDLE), 1'(wr_seen_reg)};
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= MODE_RST;
      cmd_reg <= '0;
      mrs_pend_reg <= 1'b0;
      cmd_pend_reg <= 1'b0;
      err_lat_reg <= 1'b0;
      err_busy_reg <= 1'b0;
    end else if (ce) begin
      if (mrs_take) mrs_pend_reg <= 1'b0;
      if (issue) cmd_pend_reg <= 1'b0;
      if (reg_wr) begin
        case (dph_addr_reg)
          A_MODE: begin
            // a too-low latency with the long preamble is refused, mode left as it was
            if (hwdata[PRE2_BIT] && hwdata[CLAT_LSB +: FW] <= CLAT_MIN) begin
              err_lat_reg <= 1'b1;
            end else begin
              mode_reg <= hwdata[AW-1:0];
              mrs_pend_reg <= 1'b1;
            end
          end
          A_CMD: begin
            if (cmd_pend_reg && !issue) begin
              err_busy_reg <= 1'b1;
            end else begin
              cmd_reg <= hwdata[CMDW-1:0];
              cmd_pend_reg <= 1'b1;
            end
          end
          A_STAT: begin
            if (hwdata[4]) err_lat_reg <= 1'b0;
            if (hwdata[5]) err_busy_reg <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && push) fifo_mem[wp_reg] <= hwdata[DW-1:0];
    if (ce && pop) burst_arr[fill_reg[2:0]] <= fifo_mem[rp_reg];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      fcnt_reg <= '0;
    end else if (ce) begin
      if (push) wp_reg <= (wp_reg == PW'(FD - 1)) ? '0 : wp_reg + 1'b1;
      if (pop) rp_reg <= (rp_reg == PW'(FD - 1)) ? '0 : rp_reg + 1'b1;
      fcnt_reg <= fcnt_reg + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  // link clock made here; outputs move on its falling half so the far end sees them settled
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= '0;
      lclk_reg <= 1'b0;
    end else if (ce) begin
      div_reg <= (div_reg == 8'(LDIV - 1)) ? 8'h00 : div_reg + 8'h01;
      if (div_reg == 8'(LDIV - 1)) lclk_reg <= 1'b1;
      else if (ltick) lclk_reg <= 1'b0;
    end
  end

  always_comb begin
    go_ok = 1'b1;
    if (op == DWB_WR || op == DWB_RD) begin
      go_ok = gap_reg >= ccd_min(pre2);
    end
    if (op == DWB_RD && wr_seen_reg) begin
      go_ok = go_ok && (end_reg >= ((c_bg == last_bg_reg) ? 8'(WTR_L) : 8'(WTR_S)));
    end
    if (op == DWB_PRE && wr_seen_reg && c_bg == last_bg_reg && c_ba == last_ba_reg) begin
      go_ok = end_reg >= {3'h0, mode_reg[WR_LSB +: FW]};
    end
  end

  always_comb begin
    cmd_addr = '0;
    cmd_addr[2:0] = cmd_reg[COL_LSB +: 3];
    cmd_addr[CHOP_BIT] = cmd_reg[CSEL_BIT];
    cmd_addr[AP_BIT] = cmd_reg[APC_BIT];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_reg <= 8'hff;
      end_reg <= 8'hff;
      last_bg_reg <= '0;
      last_ba_reg <= '0;
      wr_seen_reg <= 1'b0;
    end else if (ce && ltick) begin
      if (issue && (op == DWB_WR || op == DWB_RD)) gap_reg <= 8'h00;
      else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
      if (burst_end) end_reg <= 8'h00;
      else if (end_reg != 8'hff) end_reg <= end_reg + 8'h01;
      if (issue && op == DWB_WR) begin
        last_bg_reg <= c_bg;
        last_ba_reg <= c_ba;
        wr_seen_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= C_IDLE;
      cmd_o_reg <= DWB_NOP;
      bg_o_reg <= '0;
      ba_o_reg <= '0;
      addr_o_reg <= '0;
      dq_o_reg <= '0;
      dqen_o_reg <= 1'b0;
      fill_reg <= '0;
      beats_reg <= BEATS8;
      beat_reg <= '0;
      lat_reg <= '0;
      lead_reg <= '0;
    end else if (ce) begin
      if (ltick) cmd_o_reg <= DWB_NOP;
      unique case (st_reg)
        C_IDLE: begin
          if (mrs_take) begin
            cmd_o_reg <= DWB_MRS;
            addr_o_reg <= mode_reg;
          end else if (cmd_pend_reg && !mrs_pend_reg) begin
            fill_reg <= '0;
            beats_reg <= is_chop(mode_reg[BL_LSB +: 2], cmd_reg[CSEL_BIT]) ? BEATS4
                         : BEATS8;
            st_reg <= (op == DWB_WR) ? C_FILL : C_WAIT;
          end
        end
        C_FILL: begin
          if (pop) begin
            fill_reg <= fill_reg + 4'h1;
            if (fill_reg == beats_reg - 4'h1) st_reg <= C_WAIT;
          end
        end
        C_WAIT: begin
          if (issue) begin
            cmd_o_reg <= op;
            bg_o_reg <= c_bg;
            ba_o_reg <= c_ba;
            addr_o_reg <= cmd_addr;
            lat_reg <= {1'b0, mode_reg[ADDL_LSB +: FW]} + {1'b0, mode_reg[CLAT_LSB +: FW]};
            lead_reg <= pre2 ? 6'h03 : 6'h02;
            st_reg <= (op == DWB_WR) ? C_LAT : C_IDLE;
          end
        end
        C_LAT: begin
          if (ltick) begin
            if (lat_reg == lead_reg) dqen_o_reg <= 1'b1;
            if (lat_reg == 6'h01) begin
              dq_o_reg <= burst_arr[0];
              beat_reg <= 4'h1;
              st_reg <= C_DATA;
            end else begin
              lat_reg <= lat_reg - 6'h01;
            end
          end
        end
        C_DATA: begin
          if (burst_end) begin
            dq_o_reg <= '0;
            dqen_o_reg <= 1'b0;
            st_reg <= C_IDLE;
          end else if (ltick) begin
            dq_o_reg <= burst_arr[beat_reg[2:0]];
            beat_reg <= beat_reg + 4'h1;
          end
        end
      endcase
    end
  end

  assign hreadyout = hready_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;
  assign lnk.lclk = lclk_reg;
  assign lnk.cmd = cmd_o_reg;
  assign lnk.bg = bg_o_reg;
  assign lnk.ba = ba_o_reg;
  assign lnk.addr = addr_o_reg;
  assign lnk.dq = dq_o_reg;
  assign lnk.dq_en = dqen_o_reg;
endmodule

// [bench/dwb_link_chk.sv]
`timescale 1ns/100ps
module dwb_link_chk #(
  parameter int LDIV = 8,
  parameter int WTR_S = 2,
  parameter int WTR_L = 6
) (
  input logic mclk,
  input logic sys_rst,
  input logic lclk,
  input dwb_pkg::dwb_cmd_t cmd,
  input logic [1:0] bg,
  input logic [1:0] ba,
  input logic [dwb_pkg::AW-1:0] addr,
  input logic [dwb_pkg::DW-1:0] dq,
  input logic dq_en
);
  import dwb_pkg::*;
  logic lclk_d, en_d, wr_on, nc, pre2;
  logic [AW-1:0] mode_reg;
  logic [1:0] wbg, wba;
  logic [3:0] beats;
  logic [9:0] wl_cnt, en_cnt, ccd_cnt;
  logic [11:0] end_cnt;
  logic [5:0] wl;
  // a command is new on the first sample after the falling link edge that launched it
  assign nc = !lclk && lclk_d && cmd != DWB_NOP;
  assign pre2 = mode_reg[PRE2_BIT];
  assign wl = {1'b0, mode_reg[ADDL_LSB +: FW]} + {1'b0, mode_reg[CLAT_LSB +: FW]};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lclk_d <= 1'b0;
      en_d <= 1'b0;
      en_cnt <= 10'h000;
    end else begin
      lclk_d <= lclk;
      en_d <= dq_en;
      en_cnt <= dq_en ? en_cnt + 10'h001 : 10'h000;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) mode_reg <= MODE_RST;
    else if (nc && cmd == DWB_MRS) mode_reg <= addr;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_on <= 1'b0;
      wl_cnt <= 10'h000;
      beats <= BEATS8;
      wbg <= 2'h0;
      wba <= 2'h0;
    end else if (nc && cmd == DWB_WR && !wr_on) begin
      wr_on <= 1'b1;
      wl_cnt <= 10'h001;
      wbg <= bg;
      wba <= ba;
      beats <= (mode_reg[1:0] == BL_FIX4 || (mode_reg[1:0] == BL_PCMD && !addr[CHOP_BIT]))
        ? BEATS4 : BEATS8;
    end else if (wr_on) begin
      wl_cnt <= wl_cnt + 10'h001;
      wr_on <= !(en_d && !dq_en);
    end
  end

  // saturating, so nothing fires before the first write or read
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) ccd_cnt <= 10'h3ff;
    else if (nc && (cmd == DWB_WR || cmd == DWB_RD)) ccd_cnt <= 10'h001;
    else if (ccd_cnt != 10'h3ff) ccd_cnt <= ccd_cnt + 10'h001;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) end_cnt <= 12'hfff;
    else if (en_d && !dq_en) end_cnt <= 12'h001;
    else if (end_cnt != 12'hfff) end_cnt <= end_cnt + 12'h001;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_new_col;
    nc && (cmd == DWB_WR || cmd == DWB_RD);
  endsequence
  sequence s_hold;
    $stable(cmd) [*7];
  endsequence

  AST_CMD_EDGE: assert property ($changed(cmd) |-> $fell(lclk))
    else $error("command changed away from a falling link edge");
  AST_CMD_HOLD: assert property (nc |=> s_hold)
    else $error("command not held for one link period");
  AST_DQ_EDGE: assert property ($changed(dq) || $changed(dq_en) |-> $fell(lclk))
    else $error("write data moved away from a falling link edge");
  AST_WL: assert property ($rose(dq_en) && wr_on |->
    wl_cnt == 10'((wl - (pre2 ? 6'h2 : 6'h1)) * LDIV))
    else $error("write data window does not start at write latency");
  AST_LEN: assert property ($fell(dq_en) |->
    en_cnt == 10'(((pre2 ? 2 : 1) + beats) * LDIV))
    else $error("burst length on the link does not match the mode");
  AST_CCD: assert property (s_new_col |-> ccd_cnt >= 10'((pre2 ? 6 : 5) * LDIV))
    else $error("column commands too close");
  AST_WTR: assert property (nc && cmd == DWB_RD |->
    end_cnt >= 12'(((bg == wbg) ? WTR_L : WTR_S) * LDIV))
    else $error("read too soon after write data");
  AST_WREC: assert property (nc && cmd == DWB_PRE && bg == wbg && ba == wba |->
    end_cnt >= 12'(mode_reg[WR_LSB +: FW] * LDIV))
    else $error("precharge before write recovery");
  AST_CLAT: assert property (nc && cmd == DWB_MRS && addr[PRE2_BIT] |->
    addr[CLAT_LSB +: FW] > CLAT_MIN)
    else $error("two-clock preamble with minimum column latency");
endmodule

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import dwb_pkg::*;
  localparam logic [1:0] BLS [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
  localparam logic [5:0] SELS = 6'b110101;
  localparam logic [5:0] CHOPS = 6'b101000;
  logic mclk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r, m;
  logic [1:0] htrans, g;
  logic [6:0] mem_raddr;
  logic [15:0] mem_rdata;
  logic burst_chopped, recovery_busy, precharge_pulse, burst_done_pulse;
  int bad_count, checks_done, cyc, done_cnt, t_done, t_pre, i;
  dwb_link_if lnk ();
  dwb_ctrl_end u_dwb_ctrl_end (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lnk(lnk.ctrl));
  dwb_mem_end u_dwb_mem_end (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .lnk(lnk.mem),
    .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .burst_chopped(burst_chopped),
    .recovery_busy(recovery_busy), .precharge_pulse(precharge_pulse),
    .burst_done_pulse(burst_done_pulse));
  dwb_link_chk u_dwb_link_chk (.mclk(mclk), .sys_rst(sys_rst), .lclk(lnk.lclk), .cmd(lnk.cmd),
    .bg(lnk.bg), .ba(lnk.ba), .addr(lnk.addr), .dq(lnk.dq), .dq_en(lnk.dq_en));

  task automatic summarize();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // entered right after a rising edge; hready is the slave's own hreadyout
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // a second command while one is pending would be dropped, so wait for the slot
  task automatic cmd(input logic [31:0] w);
    logic [31:0] s;
    do bus(A_STAT, 1'b0, 32'h0, s); while (s[3] !== 1'b0);
    bus(A_CMD, 1'b1, w, s);
  endtask

  function automatic logic [31:0] cmdw(input logic [2:0] op, input logic [1:0] gg,
    input logic [1:0] b, input logic [2:0] c, input logic s, input logic ap);
    return {20'h0, ap, s, c, b, gg, op};
  endfunction

  function automatic logic [31:0] mw(input logic [1:0] bl, input logic p2,
    input logic [4:0] clat, input logic [4:0] addl, input logic [4:0] wr);
    return {14'h0, wr, addl, clat, p2, bl};
  endfunction

  task automatic do_wr(input logic [1:0] gg, input logic [1:0] b, input logic [2:0] c,
    input logic s, input logic ap, input int n, input logic [15:0] base,
    input logic [31:0] nxt, input logic dup);
    logic [31:0] q;
    logic [2:0] cc;
    int k0;
    int j;
    k0 = done_cnt;
    bus(A_WDATA, 1'b1, {16'h0, base}, q);
    bus(A_WDATA, 1'b1, {16'h0, base + 16'h1}, q);
    bus(A_STAT, 1'b0, 32'h0, q);
    check(q & 32'hc0, 32'h40);
    cmd(cmdw(3'h2, gg, b, c, s, ap));
    if (dup) bus(A_CMD, 1'b1, 32'h4, q);
    for (j = 2; j < n; j++) bus(A_WDATA, 1'b1, {16'h0, base + j[15:0]}, q);
    if (nxt != 32'h0) cmd(nxt);
    while (done_cnt == k0) @(posedge mclk);
    check({31'h0, recovery_busy}, 32'h1);
    for (j = 0; j < n; j++) begin
      cc = (n == 8) ? c + j[2:0] : {c[2], c[1:0] + j[1:0]};
      mem_raddr <= {gg, b, cc};
      @(posedge mclk);
      @(posedge mclk);
      check({16'h0, mem_rdata}, {16'h0, base + j[15:0]});
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (burst_done_pulse === 1'b1) begin
      done_cnt++;
      t_done = cyc;
    end
    if (precharge_pulse === 1'b1) t_pre = cyc;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mem_raddr = 7'h00;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    bus(A_MODE, 1'b0, 32'h0, r);
    check(r, {14'h0, MODE_RST});
    bus(A_STAT, 1'b0, 32'h0, r);
    check(r, 32'h80);
    bus(8'h10, 1'b1, 32'hffff, r);
    bus(8'h10, 1'b0, 32'h0, r);
    check(r, 32'h0);
    // fixed eight, per-command eight/four/eight, fixed four with select high
    for (i = 0; i < 6; i++) begin
      m = mw(BLS[i], i == 5, (i == 5) ? 5'h0a : 5'h09, (i == 3) ? 5'h02 : 5'h00, 5'h05);
      bus(A_MODE, 1'b1, m, r);
      bus(A_MODE, 1'b0, 32'h0, r);
      check(r, m);
      g = i[1:0];
      do_wr(g, {1'b0, i[2]}, 3'h5, SELS[i], 1'b0, CHOPS[i] ? 4 : 8, 16'(i * 256),
        cmdw(3'h3, i[0] ? ~g : g, 2'h0, 3'h0, 1'b0, 1'b0), 1'b0);
      check({31'h0, burst_chopped}, {31'h0, CHOPS[i]});
    end
    bus(A_MODE, 1'b1, mw(BL_PCMD, 1'b1, 5'h09, 5'h00, 5'h05), r);
    bus(A_MODE, 1'b0, 32'h0, r);
    check(r, m);
    bus(A_STAT, 1'b0, 32'h0, r);
    check(r & 32'h10, 32'h10);
    check({31'h0, hresp}, 32'h0);
    bus(A_MODE, 1'b1, mw(BL_PCMD, 1'b0, 5'h09, 5'h00, 5'h05), r);
    do_wr(2'h1, 2'h1, 3'h2, 1'b1, 1'b0, 8, 16'h7000, cmdw(3'h4, 2'h1, 2'h1, 3'h0, 1'b0, 1'b0),
      1'b1);
    bus(A_STAT, 1'b0, 32'h0, r);
    check(r & 32'h20, 32'h20);
    bus(A_STAT, 1'b1, 32'h30, r);
    bus(A_STAT, 1'b0, 32'h0, r);
    check(r & 32'h30, 32'h0);
    while (t_pre <= t_done) @(posedge mclk);
    check(32'(t_pre - t_done >= 48), 32'h1);
    // auto-precharge must wait out recovery counted from the rise after the last beat
    do_wr(2'h2, 2'h0, 3'h6, 1'b0, 1'b1, 4, 16'h7100, 32'h0, 1'b0);
    while (t_pre <= t_done) @(posedge mclk);
    // recovery of 5 starts one link clock after the last beat, so six link clocks in all
    check(32'(t_pre - t_done), 32'((5 + 1) * LDIV_DEF));
    check({31'h0, recovery_busy}, 32'h0);
    summarize();
  end
endmodule
